// ---- src/dsfi_consts.svh ----
`ifndef DSFI_CONSTS_SVH
`define DSFI_CONSTS_SVH

// led timebase: one flash phase per slot, 200 ms by default
`define DSFI_CLK_HZ 200000000
`define DSFI_FLASH_MS 200
`define DSFI_FLASH_CYC ((`DSFI_CLK_HZ / 1000) * `DSFI_FLASH_MS)
`define DSFI_BLINK_MS 200
`define DSFI_BLINK_CYC ((`DSFI_CLK_HZ / 1000) * `DSFI_BLINK_MS)
// one slot = flash phase; a pattern frame is 10 slots (2 s)
`define DSFI_SLOTS 4'd10
// object index and subindex that carry the over-temperature flag
`define DSFI_TEMP_OBJ 16'h2019
`define DSFI_TEMP_SUB 8'h01
// status word bit positions
`define DSFI_ST_OVERTEMP 0
`define DSFI_ST_LOCKED 1
`define DSFI_ST_TORQUE 2
`define DSFI_ST_STAGE_EN 3
// sync timeout object index
`define DSFI_SYNC_OBJ 16'h1006
// lead/lag counter width and locked timeout counter width
`define DSFI_LL_W 16
`define DSFI_LT_W 24

`endif

// ---- src/dsfi_pkg.sv ----
package dsfi_pkg;

    typedef enum logic [1:0] {
        DSFI_CL_OFF,
        DSFI_CL_FIXED,
        DSFI_CL_VARIABLE,
        DSFI_CL_TORQUE
    } dsfi_cl_mode_t;

    typedef enum logic [1:0] {
        DSFI_IN_GENERAL,
        DSFI_IN_HOME,
        DSFI_IN_LIMIT,
        DSFI_IN_CAPTURE
    } dsfi_in_role_t;

    typedef enum logic [1:0] {
        DSFI_NMT_PREOP,
        DSFI_NMT_OPER,
        DSFI_NMT_STOPPED,
        DSFI_NMT_INIT
    } dsfi_nmt_t;

    typedef struct packed {
        logic main_ok;
        logic main_bad;
        logic aux_ok;
        logic aux_bad;
    } dsfi_supply_t;

    typedef struct packed {
        logic bus_off;
        logic err_warn;
        logic guard_evt;
        logic sync_tmo;
    } dsfi_can_err_t;

    typedef struct packed {
        logic [6:0] torque_percent;
        logic [15:0] torque_speed_limit;
    } dsfi_torque_t;

    typedef struct packed {
        logic green;
        logic red;
    } dsfi_led_t;

endpackage

// ---- src/dsfi_top.sv ----
`timescale 1ns/1ps
`include "dsfi_consts.svh"
// Notes on behaviour
// R1: selecting profile torque operation switches the loop into torque mode automatically.
// R2: torque mode drives torque_percent and caps speed at torque_speed_limit.
// R3: input one may serve as a position capture input beside other roles.
// R4: each power output selects general purpose or brake control.
// R5: signal output selects general purpose or high speed trip.
// R6: over-temperature de-energizes the stage and sets the temperature status flag.
// R7: closed loop on, lead/lag over limit or timeout disables stage, raises locked error.
// R8: locked error never rises with closed loop off; state readable in status.
// R9: power led: off, solid/flash green, solid/flash red per supply state.
// R10: network led solid green when operational.
// R11: network led single green flash when stopped.
// R12: network led continuous green flashing when pre-operational.
// R13: network led solid red when bus-off.
// R14: network led single red flash at error counter warning.
// R15: network led red double flash after guard or heartbeat event.
// R16: network led red triple flash on sync timeout.
// R17: closed loop on, stopped or locked shaft raises the locked error.
// R18: closed loop compares encoder to commanded steps within control bounds.
// R19: patterns come from a free-running timebase; red beats green. Power led shows main_ok green over aux_bad red instead.
module dsfi_top #(
    parameter int unsigned FLASH_CYC = `DSFI_FLASH_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire dsfi_pkg::dsfi_cl_mode_t cl_mode,
    input wire logic profile_torque,
    input wire dsfi_pkg::dsfi_torque_t torque_cfg,
    input wire logic [`DSFI_LL_W-1:0] ll_limit,
    input wire logic [`DSFI_LT_W-1:0] locked_rotor_timeout,
    input wire logic cmd_step,
    input wire logic cmd_dir,
    input wire logic enc_step,
    input wire logic enc_dir,
    input wire logic fault_clear,
    input wire logic overtemp_pin,
    input wire logic [3:0] gp_in_pin,
    input wire dsfi_pkg::dsfi_in_role_t in1_role,
    input wire logic [1:0] pwr_out_brake_sel,
    input wire logic [1:0] pwr_out_gp,
    input wire logic brake_release,
    input wire logic sig_out_trip_sel,
    input wire logic sig_out_gp,
    input wire logic trip_hit,
    input wire dsfi_pkg::dsfi_supply_t supply_pin,
    input wire dsfi_pkg::dsfi_nmt_t nmt_state,
    input wire dsfi_pkg::dsfi_can_err_t can_err,
    output logic stage_en,
    output logic torque_mode,
    output logic [6:0] torque_level,
    output logic [15:0] speed_cap,
    output logic [3:0] gp_in_level,
    output logic capture_pulse,
    output logic [1:0] pwr_out,
    output logic sig_out,
    output logic [3:0] status,
    output logic [15:0] temp_obj_index,
    output logic [7:0] temp_obj_sub,
    output logic [15:0] sync_obj_index,
    output dsfi_pkg::dsfi_led_t power_led,
    output dsfi_pkg::dsfi_led_t net_led
);

    // =====================================================================
    // pin synchronisers
    // =====================================================================
    // supply, temperature and inputs come from pins: two stages before any logic
    logic [8:0] sync1_r;
    logic [8:0] sync2_r;
    logic [8:0] pin_raw;
    assign pin_raw = {overtemp_pin, gp_in_pin, supply_pin};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1_r <= 9'h000;
            sync2_r <= 9'h000;
        end else begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
        end
    end

    wire overtemp_s = sync2_r[8];
    wire [3:0] gp_in_s = sync2_r[7:4];
    dsfi_pkg::dsfi_supply_t supply_s;
    assign supply_s = sync2_r[3:0];

    // =====================================================================
    // closed loop supervision
    // =====================================================================
    wire closed_loop = (cl_mode != dsfi_pkg::DSFI_CL_OFF) || profile_torque;
    wire torque_sel = profile_torque || (cl_mode == dsfi_pkg::DSFI_CL_TORQUE); // [R1]

    logic signed [`DSFI_LL_W:0] lead_lag_r;
    logic [`DSFI_LT_W-1:0] stall_cnt_r;
    logic locked_r;
    logic overtemp_r;

    function automatic logic signed [1:0] step_delta(input logic stp, input logic dir);
        step_delta = stp ? (dir ? 2'sd1 : -2'sd1) : 2'sd0;
    endfunction

    wire signed [`DSFI_LL_W:0] ll_nxt = lead_lag_r
        + (`DSFI_LL_W+1)'(step_delta(cmd_step, cmd_dir))
        - (`DSFI_LL_W+1)'(step_delta(enc_step, enc_dir)); // [R18]
    wire [`DSFI_LL_W:0] ll_abs = ll_nxt[`DSFI_LL_W] ? (`DSFI_LL_W+1)'(-ll_nxt) : ll_nxt;
    wire ll_over = ll_abs > {1'b0, ll_limit}; // [R7]
    // shaft counts as stopped when steps are commanded but no encoder edge comes back
    wire lt_expire = (locked_rotor_timeout != '0) && (stall_cnt_r >= locked_rotor_timeout);
    wire lock_evt = closed_loop && (ll_over || lt_expire); // [R7] [R8] [R17]

    // lead/lag restarts from zero while locked, so a clear cannot re-trip at once
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lead_lag_r <= '0;
        end else if (!closed_loop || locked_r) begin
            lead_lag_r <= '0;
        end else begin
            lead_lag_r <= ll_nxt;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stall_cnt_r <= '0;
        end else if (!closed_loop || enc_step || lead_lag_r == '0) begin
            stall_cnt_r <= '0;
        end else if (!lt_expire) begin
            stall_cnt_r <= stall_cnt_r + 1'b1; // [R17]
        end
    end

    // set wins over clear for both fault flags
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            locked_r <= 1'b0;
            overtemp_r <= 1'b0;
        end else begin
            locked_r <= lock_evt || (locked_r && !fault_clear && closed_loop); // [R7] [R8]
            overtemp_r <= overtemp_s || (overtemp_r && !fault_clear); // [R6]
        end
    end

    // =====================================================================
    // power stage and torque outputs
    // =====================================================================
    // the stage drops at the same edge that latches a fault, not one later
    wire stage_on_nxt = !overtemp_r && !overtemp_s && !locked_r && !lock_evt; // [R6] [R7]
    wire [6:0] torque_level_nxt = torque_sel ? torque_cfg.torque_percent : 7'h00; // [R2]
    wire [15:0] speed_cap_nxt = torque_sel ? torque_cfg.torque_speed_limit : 16'hFFFF; // [R2]

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stage_en <= 1'b0;
            torque_mode <= 1'b0;
            torque_level <= 7'h00;
            speed_cap <= 16'h0000;
        end else begin
            stage_en <= stage_on_nxt;
            torque_mode <= torque_sel; // [R1]
            torque_level <= torque_level_nxt;
            speed_cap <= speed_cap_nxt;
        end
    end

    assign status[`DSFI_ST_OVERTEMP] = overtemp_r; // [R6]
    assign status[`DSFI_ST_LOCKED] = locked_r; // [R8]
    assign status[`DSFI_ST_TORQUE] = torque_mode;
    assign status[`DSFI_ST_STAGE_EN] = stage_en;
    assign temp_obj_index = `DSFI_TEMP_OBJ; // [R6]
    assign temp_obj_sub = `DSFI_TEMP_SUB;
    assign sync_obj_index = `DSFI_SYNC_OBJ;

    // =====================================================================
    // configurable i/o
    // =====================================================================
    logic in1_d_r;
    wire in1_is_cap = (in1_role == dsfi_pkg::DSFI_IN_CAPTURE);
    wire capture_nxt = in1_is_cap && gp_in_s[0] && !in1_d_r; // [R3]
    // brake holds while the stage is off, released only on request
    wire [1:0] brake_drv = {2{brake_release && stage_en}};
    wire [1:0] pwr_out_nxt = (pwr_out_brake_sel & brake_drv)
        | (~pwr_out_brake_sel & pwr_out_gp); // [R4]
    wire sig_out_nxt = sig_out_trip_sel ? trip_hit : sig_out_gp; // [R5]

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            in1_d_r <= 1'b0;
            gp_in_level <= 4'h0;
            capture_pulse <= 1'b0;
        end else begin
            in1_d_r <= gp_in_s[0];
            gp_in_level <= gp_in_s;
            capture_pulse <= capture_nxt;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pwr_out <= 2'h0;
            sig_out <= 1'b0;
        end else begin
            pwr_out <= pwr_out_nxt;
            sig_out <= sig_out_nxt;
        end
    end

    // =====================================================================
    // led timebase
    // =====================================================================
    // slot length is a parameter so a bench can run whole frames in a few hundred cycles
    logic [26:0] tb_cnt_r;
    logic [3:0] slot_r;
    logic blink_r;
    wire tb_tick = (tb_cnt_r == 27'(FLASH_CYC - 1));
    wire slot_last = (slot_r == `DSFI_SLOTS - 4'd1);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tb_cnt_r <= '0;
            slot_r <= 4'h0;
        end else if (tb_tick) begin
            tb_cnt_r <= '0;
            slot_r <= slot_last ? 4'h0 : slot_r + 4'd1; // [R19]
        end else begin
            tb_cnt_r <= tb_cnt_r + 27'd1;
        end
    end

    // blink shares the tick since both phases are 200 ms
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            blink_r <= 1'b0;
        end else if (tb_tick) begin
            blink_r <= !blink_r; // [R19]
        end
    end

    // n flashes: on in slots 0,2,4.. for n flashes, rest of the frame off
    function automatic logic flash_n(input logic [3:0] slot, input logic [1:0] n);
        flash_n = !slot[0] && (slot[3:1] < {1'b0, n});
    endfunction

    // =====================================================================
    // led encoders
    // =====================================================================
    logic pwr_g_nxt;
    logic pwr_r_nxt;
    logic net_g_nxt;
    logic net_r_nxt;

    always_comb begin
        pwr_g_nxt = 1'b0;
        pwr_r_nxt = 1'b0;
        if (supply_s.main_bad) begin
            pwr_r_nxt = 1'b1; // [R9]
        end else if (supply_s.main_ok) begin
            pwr_g_nxt = 1'b1; // [R9]
        end else if (supply_s.aux_bad) begin
            pwr_r_nxt = blink_r; // [R9]
        end else if (supply_s.aux_ok) begin
            pwr_g_nxt = blink_r; // [R9]
        end
    end

    always_comb begin
        net_g_nxt = 1'b0;
        net_r_nxt = 1'b0;
        if (can_err.bus_off) begin
            net_r_nxt = 1'b1; // [R13] [R19]
        end else if (can_err.sync_tmo) begin
            net_r_nxt = flash_n(slot_r, 2'd3); // [R16]
        end else if (can_err.guard_evt) begin
            net_r_nxt = flash_n(slot_r, 2'd2); // [R15]
        end else if (can_err.err_warn) begin
            net_r_nxt = flash_n(slot_r, 2'd1); // [R14]
        end
        if (!net_r_nxt || can_err == '0) begin
            unique case (nmt_state)
                dsfi_pkg::DSFI_NMT_OPER: net_g_nxt = 1'b1; // [R10]
                dsfi_pkg::DSFI_NMT_STOPPED: net_g_nxt = flash_n(slot_r, 2'd1); // [R11]
                dsfi_pkg::DSFI_NMT_PREOP: net_g_nxt = blink_r; // [R12]
                dsfi_pkg::DSFI_NMT_INIT: net_g_nxt = 1'b0;
            endcase
        end
        // red pattern owns the led whenever any error is present
        if (can_err != '0) begin
            net_g_nxt = 1'b0; // [R19]
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            power_led <= '0;
            net_led <= '0;
        end else begin
            power_led <= '{green: pwr_g_nxt, red: pwr_r_nxt};
            net_led <= '{green: net_g_nxt, red: net_r_nxt};
        end
    end

endmodule

// ---- test/dsfi_master_model.sv ----
`timescale 1ns/1ps
// ====================
// network master: sets node state and error flags
module dsfi_master_model (
    input logic clk,
    input logic [5:0] req,
    output dsfi_pkg::dsfi_nmt_t nmt_state,
    output dsfi_pkg::dsfi_can_err_t can_err
);
    // takes the request at a rising edge and answers by non-blocking update
    always @(posedge clk) begin
        nmt_state <= dsfi_pkg::dsfi_nmt_t'(req[5:4]);
        can_err <= req[3:0];
    end
endmodule

// ---- test/dsfi_props.sv ----
`timescale 1ns/1ps
// ====================
// port checker
module dsfi_props (
    input logic clk,
    input logic rstn,
    input dsfi_pkg::dsfi_cl_mode_t cl_mode,
    input logic profile_torque,
    input dsfi_pkg::dsfi_torque_t torque_cfg,
    input logic overtemp_pin,
    input dsfi_pkg::dsfi_in_role_t in1_role,
    input logic sig_out_trip_sel,
    input logic trip_hit,
    input dsfi_pkg::dsfi_supply_t supply_pin,
    input dsfi_pkg::dsfi_can_err_t can_err,
    input logic stage_en,
    input logic torque_mode,
    input logic [6:0] torque_level,
    input logic [15:0] speed_cap,
    input logic capture_pulse,
    input logic sig_out,
    input logic [3:0] status,
    input logic [15:0] temp_obj_index,
    input logic [7:0] temp_obj_sub,
    input logic [15:0] sync_obj_index,
    input dsfi_pkg::dsfi_led_t power_led,
    input dsfi_pkg::dsfi_led_t net_led
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // pins pass two sync stages, so a level must stand three edges
    sequence s_hot;
        overtemp_pin [*3];
    endsequence
    sequence s_main_bad;
        supply_pin.main_bad [*3];
    endsequence
    sequence s_cap_once;
        in1_role == dsfi_pkg::DSFI_IN_CAPTURE ##1 !capture_pulse;
    endsequence
    wire cl_off = cl_mode == dsfi_pkg::DSFI_CL_OFF && !profile_torque;
    a_temp_obj_const: assert property (temp_obj_index == 16'h2019 && temp_obj_sub == 8'h01)
        else $error("temperature object index wrong");
    a_sync_obj_const: assert property (sync_obj_index == 16'h1006)
        else $error("sync object index wrong");
    a_hot_stage_off: assert property (s_hot |=> status[0] && !stage_en)
        else $error("over temperature left stage on");
    a_lock_needs_loop: assert property (cl_off [*2] |-> !status[1])
        else $error("locked error with closed loop off");
    a_lock_stage_off: assert property ($rose(status[1]) |-> !stage_en)
        else $error("locked error left stage on");
    a_torque_follow: assert property (profile_torque |=> torque_mode &&
        torque_level == $past(torque_cfg.torque_percent) &&
        speed_cap == $past(torque_cfg.torque_speed_limit))
        else $error("torque settings not applied");
    a_trip_route: assert property (sig_out_trip_sel |=> sig_out == $past(trip_hit))
        else $error("trip output not routed");
    a_capture_role: assert property (capture_pulse |-> s_cap_once)
        else $error("capture pulse wrong");
    a_bus_off_red: assert property (can_err.bus_off |=> net_led.red && !net_led.green)
        else $error("bus off not solid red");
    a_main_bad_red: assert property (s_main_bad |=> power_led.red && !power_led.green)
        else $error("bad supply not red");
    a_red_over_green: assert property ((can_err != '0) |=> !net_led.green)
        else $error("green shown during a network error");
endmodule

// ---- test/testbench.sv ----
`timescale 1ns/1ps
bind dsfi_top dsfi_props i_dsfi_props (.*);
// ====================
// bench
module testbench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    dsfi_pkg::dsfi_cl_mode_t cl_mode = dsfi_pkg::DSFI_CL_OFF;
    dsfi_pkg::dsfi_torque_t torque_cfg = '0;
    logic [15:0] ll_limit = 16'h3;
    logic [23:0] locked_rotor_timeout = '0;
    logic profile_torque = 0, cmd_step = 0, cmd_dir = 1, enc_step = 0, enc_dir = 1;
    logic fault_clear = 0, overtemp_pin = 0, brake_release = 0, trip_hit = 0;
    logic sig_out_trip_sel = 0, sig_out_gp = 0;
    logic [3:0] gp_in_pin = '0;
    dsfi_pkg::dsfi_in_role_t in1_role = dsfi_pkg::DSFI_IN_GENERAL;
    logic [1:0] pwr_out_brake_sel = '0, pwr_out_gp = '0, pwr_out;
    dsfi_pkg::dsfi_supply_t supply_pin = 4'h8;
    logic [5:0] net_req = 6'h10;
    dsfi_pkg::dsfi_nmt_t nmt_state;
    dsfi_pkg::dsfi_can_err_t can_err;
    dsfi_pkg::dsfi_led_t power_led, net_led;
    logic stage_en, torque_mode, capture_pulse, sig_out;
    logic [6:0] torque_level;
    logic [15:0] speed_cap, temp_obj_index, sync_obj_index;
    logic [3:0] gp_in_level, status;
    logic [7:0] temp_obj_sub;
    logic [31:0] rnd = 32'hC97B;
    // a slot of a few cycles lets one whole frame of every pattern run in the test
    localparam int SLOT_CYC = 4;
    localparam int FRAME = 10 * SLOT_CYC;
    // green pattern in the high nibble, red in the low:
    // 0 off, 1..3 flashes per frame, 4 solid, 5 blinking
    logic [3:0] pw_in [5] = '{4'h8, 4'hC, 4'h0, 4'h2, 4'h1};
    logic [7:0] pw_ex [5] = '{8'h40, 8'h04, 8'h00, 8'h50, 8'h05};
    logic [5:0] nt_in [9] = '{6'h10, 6'h20, 6'h00, 6'h30, 6'h18, 6'h14, 6'h12, 6'h11, 6'h27};
    logic [7:0] nt_ex [9] = '{8'h40, 8'h10, 8'h50, 8'h00, 8'h04, 8'h01, 8'h02, 8'h03, 8'h03};
    logic [15:0] g_cnt, r_cnt;
    logic [31:0] exp_v;
    int mismatches = 0, compares = 0, cycles = 0, n, k;
    dsfi_top #(.FLASH_CYC(SLOT_CYC)) i_dsfi_top (.*);
    dsfi_master_model i_dsfi_master_model (.clk(clk), .req(net_req), .nmt_state(nmt_state),
        .can_err(can_err));
    initial forever #2.5 clk = ~clk;
    task automatic complete_run();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches = mismatches + 1;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(negedge clk);
    endtask
    task automatic pulse(input int c, input logic enc);
        repeat (c) begin
            if (enc) enc_step = 1;
            else cmd_step = 1;
            tick(1);
            enc_step = 0;
            cmd_step = 0;
            tick(1);
        end
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [1:0] exp_pwr(input logic [1:0] sel, gp, input logic br);
        return (sel & {2{br}}) | (~sel & gp);
    endfunction
    function automatic logic [15:0] lit(input logic [3:0] pat);
        return pat == 4'h4 ? 16'(FRAME) : pat == 4'h5 ? 16'(FRAME / 2) : 16'(pat * SLOT_CYC);
    endfunction
    // lit cycles of one led over a whole frame; any window of a frame sees each pattern once
    task automatic watch_frame(input logic net);
        g_cnt = '0;
        r_cnt = '0;
        repeat (FRAME) begin
            tick(1);
            g_cnt += net ? net_led.green : power_led.green;
            r_cnt += net ? net_led.red : power_led.red;
        end
    endtask
    initial begin
        tick(2);
        rstn = 1;
        tick(4);
        chk({temp_obj_index, temp_obj_sub, stage_en}, 25'h403203);
        chk(sync_obj_index, 16'h1006);
        chk(status, 4'h8);
        for (n = 0; n < 6; n++) begin
            rnd = lfsr(rnd);
            torque_cfg = rnd[22:0];
            profile_torque = (n != 5);
            tick(2);
            exp_v = n < 5 ? {9'h001, rnd[22:0]} : 32'h0000FFFF;
            chk({torque_mode, torque_level, speed_cap}, exp_v);
        end
        for (n = 0; n < 12; n++) begin
            rnd = lfsr(rnd);
            {pwr_out_brake_sel, pwr_out_gp, brake_release} = rnd[4:0];
            {sig_out_trip_sel, sig_out_gp, trip_hit} = rnd[7:5];
            tick(2);
            chk(pwr_out, exp_pwr(pwr_out_brake_sel, pwr_out_gp, brake_release));
            chk(sig_out, sig_out_trip_sel ? trip_hit : sig_out_gp);
        end
        for (n = 0; n < 2; n++) begin
            in1_role = n ? dsfi_pkg::DSFI_IN_CAPTURE : dsfi_pkg::DSFI_IN_GENERAL;
            gp_in_pin = 4'h1;
            k = 0;
            repeat (6) begin
                tick(1);
                if (capture_pulse === 1'b1) k++;
            end
            chk({gp_in_level, k[3:0]}, {4'h1, n[3:0]});
            gp_in_pin = 4'h0;
            tick(4);
        end
        cl_mode = dsfi_pkg::DSFI_CL_FIXED;
        pulse(3, 0);
        chk(status[1], 0);
        pulse(1, 0);
        chk({status[1], stage_en}, 2'b10);
        pulse(4, 1);
        ll_limit = 16'h64;
        locked_rotor_timeout = 24'h14;
        fault_clear = 1;
        tick(1);
        fault_clear = 0;
        tick(1);
        chk({status[1], stage_en}, 2'b01);
        pulse(1, 0);
        tick(10);
        chk(status[1], 0);
        tick(20);
        chk({status[1], stage_en}, 2'b10);
        pulse(1, 1);
        cl_mode = dsfi_pkg::DSFI_CL_OFF;
        ll_limit = 16'h3;
        tick(2);
        pulse(5, 0);
        chk({status[1], stage_en}, 2'b01);
        overtemp_pin = 1;
        tick(4);
        chk({status[0], stage_en}, 2'b10);
        overtemp_pin = 0;
        tick(4);
        chk(status[0], 1);
        fault_clear = 1;
        tick(1);
        fault_clear = 0;
        tick(2);
        chk({status[0], stage_en}, 2'b01);
        for (n = 0; n < 5; n++) begin
            supply_pin = pw_in[n];
            tick(5);
            watch_frame(0);
            exp_v = {lit(pw_ex[n][7:4]), lit(pw_ex[n][3:0])};
            chk({g_cnt, r_cnt}, exp_v);
        end
        for (n = 0; n < 9; n++) begin
            net_req = nt_in[n];
            tick(4);
            watch_frame(1);
            exp_v = {lit(nt_ex[n][7:4]), lit(nt_ex[n][3:0])};
            chk({g_cnt, r_cnt}, exp_v);
        end
        complete_run();
    end
endmodule
